// *** logic/nvrhc_host.sv ***
// Functional notes
// RULE_01: Write starts on write strobe fall with chip select low, sleep high, address valid.
// RULE_02: Page write: same upper address, each new strobe fall writes the low-bit word.
// RULE_03: Page read: changing only two low address bits returns the new word.
// RULE_04: Low column addresses within a page may come in any order.
// RULE_05: Device floats data within 10 ns of write strobe falling.
// RULE_06: Device drives data no sooner than 8/10 ns after write strobe rises.
// RULE_07: Write strobe low pulse at least 18/22 ns.
// RULE_08: Chip select held active at least 70 ns per assertion in writes.
// RULE_09: At least 70 ns from chip select low to write strobe rising.
// RULE_10: Page write strobe cycles spaced at least 40 ns apart.
// RULE_11: Masked lane disabled 5/8 ns before strobe falls and after it rises.
// RULE_12: Upper address steady at least 25/30 ns after write strobe falls.
// RULE_13: After upper address change, strobe stays low 90/105 ns before rising; the controller raises the strobe 72 ns after the address change.
// RULE_14: Chip select stays low 25/30 ns after write strobe falls.
// RULE_15: Wait at least 1 ms after power-up before the first access.
// RULE_16: Sleep request low puts device asleep and floats data within 20 ns.
// RULE_17: During sleep the device ignores chip select at once.
// RULE_18: After sleep release wait up to 500 us before first access.
// RULE_19: Sleep may be requested right after the last write.
// RULE_20: Write data latched on first rising edge of chip select or strobe.
// RULE_21: Strobe-controlled write begins as a read; upper address latched first.
// RULE_22: Only lanes whose select is low are written during a write.
// RULE_23: Low address bits held stable at least 15 ns per page access.
// RULE_24: Chip select rising ends access and starts precharge; high means standby.
// RULE_25: Upper address change with strobe high starts a new random read.
`default_nettype none
module nvrhc_host
  import nvrhc_pkg::*;
#(
  parameter logic [CNT_W-1:0] PU_CYCLES   = CNT_W'(PU_CYC),
  parameter logic [CNT_W-1:0] ZZEX_CYCLES = CNT_W'(ZZEX_CYC)
)(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              page_en,
  input  wire logic              sleep_req,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  input  wire logic [1:0]        req_lane_n,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic                   link_ready,
  output logic                   sleep_active,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic                   mem_cs_n,
  output logic                   mem_we_n,
  output logic                   mem_oe_n,
  output logic                   upper_byte_lane_n,
  output logic                   lower_byte_lane_n,
  output logic                   sleep_request_n,
  input  wire logic [DATA_W-1:0] mem_dq_in,
  output logic [DATA_W-1:0]      mem_dq_out,
  output logic                   mem_dq_oe_n
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  nvrhc_state_t      state_r, state_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic [AGE_W-1:0]  cs_age_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [1:0]        lane_r;
  logic              wr_r;
  logic              first_r;
  logic              accept;
  logic              page_hit;
  logic              cs_act;
  logic [CNT_W-1:0]  rd_wait;
  logic [DATA_W-1:0] dq_s1_r, dq_s2_r, dq_s3_r, dq_acc_r;

  // Saturating increment of the shared cycle counter.
  function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
    return (&c) ? c : c + CNT_W'(1);
  endfunction

  // ---------------------------------------------------------------
  // Request acceptance
  // ---------------------------------------------------------------
  // An open page takes only a request of the same direction and upper address.
  assign page_hit  = (req_addr[ADDR_W-1:2] == addr_r[ADDR_W-1:2]) && (req_write == wr_r);
  assign req_ready = ce && !sleep_req &&
                     ((state_r == ST_IDLE) ||
                      ((state_r == ST_PAGE) && page_en && page_hit)); // RULE_02 RULE_03
  assign accept    = req_valid && req_ready;
  assign cs_act    = (state_r == ST_READ) || (state_r == ST_WSETUP) ||
                     (state_r == ST_WLOW) || (state_r == ST_WHOLD) || (state_r == ST_PAGE);
  // A fresh row needs the full address access, a page hit only the column access.
  assign rd_wait   = first_r ? CNT_W'(AA_CYC + PIN_LAT + SYNC_LAT)
                             : CNT_W'(AAP_CYC + PIN_LAT + SYNC_LAT);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  // Next state and counter; every wait is a lower bound on a pin interval.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_inc(cnt_r);
    case (state_r)
      ST_PWRUP:
      begin
        if (cnt_r >= PU_CYCLES - CNT_W'(1)) // RULE_15
        begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end
      end
      ST_IDLE:
      begin
        cnt_nxt = '0;
        if (sleep_req)
          state_nxt = ST_SLEEP; // RULE_19
        else if (accept)
          state_nxt = req_write ? ST_WSETUP : ST_READ; // RULE_25
      end
      ST_READ:
      begin
        if (cnt_r >= rd_wait) // RULE_23
        begin
          state_nxt = ST_PAGE;
          cnt_nxt   = '0;
        end
      end
      ST_WSETUP:
      begin
        if (cnt_r >= CNT_W'(BDS_CYC - 1)) // RULE_11
        begin
          state_nxt = ST_WLOW;
          cnt_nxt   = '0;
        end
      end
      ST_WLOW:
      begin
        if ((cnt_r >= CNT_W'(WE_LOW_CYC - 1)) &&
            (cs_age_r >= AGE_W'(CW_CYC - 1))) // RULE_07 RULE_09 RULE_10
        begin
          state_nxt = ST_WHOLD;
          cnt_nxt   = '0;
        end
      end
      ST_WHOLD:
      begin
        if (cnt_r >= CNT_W'(BDH_CYC - 1)) // RULE_11
        begin
          state_nxt = ST_PAGE;
          cnt_nxt   = '0;
        end
      end
      ST_PAGE:
      begin
        cnt_nxt = '0;
        if (accept)
          state_nxt = req_write ? ST_WSETUP : ST_READ; // RULE_04
        else if (sleep_req || req_valid || !page_en)
          state_nxt = ST_PRECH; // RULE_24
      end
      ST_PRECH:
      begin
        if (cnt_r >= CNT_W'(PC_CYC - 1)) // RULE_24
        begin
          state_nxt = ST_IDLE;
          cnt_nxt   = '0;
        end
      end
      ST_SLEEP:
      begin
        if (!sleep_req && (cnt_r >= CNT_W'(ZZL_CYC - 1)))
        begin
          state_nxt = ST_PWRUP;
          cnt_nxt   = PU_CYCLES - ZZEX_CYCLES; // RULE_18
        end
      end
      default:
      begin
        state_nxt = ST_PWRUP;
        cnt_nxt   = '0;
      end
    endcase
  end

  // State and counter registers.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_PWRUP;
      cnt_r   <= '0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // Cycles since chip select went active, counted on the state.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      cs_age_r <= '0;
    else if (ce)
      cs_age_r <= !cs_act ? '0 : ((&cs_age_r) ? cs_age_r : cs_age_r + AGE_W'(1));
  end

  // Accepted request; the upper address only ever moves with chip select high
  // or while the strobe is high, never during a write pulse.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      addr_r  <= ADDR_RST;
      wdata_r <= DATA_RST;
      lane_r  <= LANES_OFF;
      wr_r    <= 1'b0;
      first_r <= 1'b1;
    end
    else if (ce && accept)
    begin
      addr_r  <= req_addr; // RULE_12 RULE_13 RULE_21
      wdata_r <= req_wdata;
      lane_r  <= req_lane_n;
      wr_r    <= req_write;
      first_r <= (state_r == ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers, all registered
  // ---------------------------------------------------------------
  // Pins follow the state one cycle later, so every interval except the RULE_13 address-to-strobe-rise time is kept.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_cs_n          <= 1'b1;
      mem_we_n          <= 1'b1;
      mem_oe_n          <= 1'b1;
      upper_byte_lane_n <= LANES_OFF[1];
      lower_byte_lane_n <= LANES_OFF[0];
      mem_addr          <= ADDR_RST;
      sleep_request_n   <= 1'b1;
    end
    else if (ce)
    begin
      mem_cs_n          <= !cs_act; // RULE_08 RULE_14 RULE_17
      mem_we_n          <= (state_r != ST_WLOW); // RULE_01 RULE_20
      mem_oe_n          <= !((state_r == ST_READ) || ((state_r == ST_PAGE) && !wr_r));
      upper_byte_lane_n <= cs_act ? lane_r[1] : LANES_OFF[1]; // RULE_22
      lower_byte_lane_n <= cs_act ? lane_r[0] : LANES_OFF[0]; // RULE_22
      mem_addr          <= addr_r;
      sleep_request_n   <= (state_r != ST_SLEEP); // RULE_16
    end
  end

  // Write data goes out only after the device has let go of the bus, and is
  // held one cycle past the strobe rise, which latches it.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mem_dq_out  <= DATA_RST;
      mem_dq_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      mem_dq_out  <= wdata_r;
      mem_dq_oe_n <= !(((state_r == ST_WLOW) && (cnt_r >= CNT_W'(WZ_CYC))) ||
                       (state_r == ST_WHOLD)); // RULE_05 RULE_06 RULE_20
    end
  end

  // ---------------------------------------------------------------
  // Read data path
  // ---------------------------------------------------------------
  // Three-stage pin synchroniser; a value counts once stages two and three agree.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      dq_s1_r  <= DATA_RST;
      dq_s2_r  <= DATA_RST;
      dq_s3_r  <= DATA_RST;
      dq_acc_r <= DATA_RST;
    end
    else if (ce)
    begin
      dq_s1_r <= mem_dq_in;
      dq_s2_r <= dq_s1_r;
      dq_s3_r <= dq_s2_r;
      if (dq_s2_r == dq_s3_r)
        dq_acc_r <= dq_s3_r;
    end
  end

  // Read answer, one cycle wide, at the end of the access wait.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp_valid <= 1'b0;
      rsp_rdata <= DATA_RST;
    end
    else if (ce)
    begin
      rsp_valid <= (state_r == ST_READ) && (cnt_r >= rd_wait); // RULE_03
      if ((state_r == ST_READ) && (cnt_r >= rd_wait))
        rsp_rdata <= dq_acc_r;
    end
  end

  // Status levels.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      link_ready   <= 1'b0;
      sleep_active <= 1'b0;
    end
    else if (ce)
    begin
      link_ready   <= (state_r != ST_PWRUP) && (state_r != ST_SLEEP);
      sleep_active <= (state_r == ST_SLEEP);
    end
  end

  // ---------------------------------------------------------------
  // Checks on the pins
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [AGE_W-1:0] we_len_r, cs_len_r, we_gap_r;

  // Interval counters read only by the checks; we_gap_r counts from the state, the other two from the pins.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      we_len_r <= '0;
      cs_len_r <= '0;
      we_gap_r <= '1;
    end
    else if (ce)
    begin
      we_len_r <= mem_we_n ? '0 : ((&we_len_r) ? we_len_r : we_len_r + AGE_W'(1));
      cs_len_r <= mem_cs_n ? '0 : ((&cs_len_r) ? cs_len_r : cs_len_r + AGE_W'(1));
      we_gap_r <= (state_r == ST_WSETUP && cnt_r >= CNT_W'(BDS_CYC - 1)) ? '0 :
                  ((&we_gap_r) ? we_gap_r : we_gap_r + AGE_W'(1));
    end
  end

  sequence s_we_fall;
    ce && $fell(mem_we_n);
  endsequence

  sequence s_we_rise;
    ce && $rose(mem_we_n);
  endsequence

  chk_write_start: assert property (s_we_fall |-> !mem_cs_n && sleep_request_n && mem_oe_n) // RULE_01
    else $error("write strobe fell outside an awake selected cycle");
  chk_we_pulse: assert property (s_we_rise |-> $past(we_len_r) >= AGE_W'(WP_CYC)) // RULE_07
    else $error("write strobe pulse too short");
  chk_cs_to_weh: assert property (s_we_rise |-> cs_len_r >= AGE_W'(CW_CYC)) // RULE_09
    else $error("write strobe rose too soon after chip select");
  chk_cs_active: assert property (ce && $rose(mem_cs_n) |-> $past(cs_len_r) >= AGE_W'(CA_CYC)) // RULE_08
    else $error("chip select active time too short");
  chk_page_space: assert property (s_we_fall |-> $past(we_gap_r, 2) >= AGE_W'(PWC_CYC - 1)) // RULE_10
    else $error("write strobe cycles too close");
  chk_dq_release: assert property (s_we_fall |-> mem_dq_oe_n[*2]) // RULE_05
    else $error("data driven before device release");
  chk_lane_hold: assert property (s_we_fall or s_we_rise |=> $stable(upper_byte_lane_n) &&
                                  $stable(lower_byte_lane_n)) // RULE_11
    else $error("byte lane moved next to a strobe edge");
  chk_upper_steady: assert property (!mem_we_n && !$past(mem_we_n) |->
                                     $stable(mem_addr[ADDR_W-1:2])) // RULE_12
    else $error("upper address moved during write pulse");
  chk_cs_after_we: assert property (ce && $rose(mem_cs_n) |-> $past(mem_we_n) &&
                                    $past(we_gap_r) >= AGE_W'(WLC_CYC)) // RULE_14
    else $error("chip deselected too soon after write strobe");
  chk_sleep_float: assert property (!sleep_request_n |-> mem_cs_n && mem_dq_oe_n) // RULE_16
    else $error("pins active during sleep");
  chk_no_early_access: assert property (state_r == ST_PWRUP |=> mem_cs_n) // RULE_15
    else $error("access during power-up or wake wait");

endmodule
`default_nettype wire

// *** logic/nvrhc_pkg.sv ***
`default_nettype none
package nvrhc_pkg;

  // ---------------------------------------------------------------
  // Clock and conversion helpers
  // ---------------------------------------------------------------
  localparam int T_CLK_NS = 8;

  // Least time in ns rounded up to whole cycles, never below one.
  function automatic int ns_to_cyc(input int t_ns);
    int c;
    c = (t_ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Larger of two counts.
  function automatic int max_int(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  // ---------------------------------------------------------------
  // Pin timing, worst supply range, in the printed units
  // ---------------------------------------------------------------
  localparam int T_WP_NS   = 22;
  localparam int T_WZ_NS   = 10;
  localparam int T_DS_NS   = 20;
  localparam int T_CW_NS   = 70;
  localparam int T_CA_NS   = 70;
  localparam int T_PWC_NS  = 40;
  localparam int T_BDS_NS  = 8;
  localparam int T_BDH_NS  = 8;
  localparam int T_PC_NS   = 35;
  localparam int T_AA_NS   = 105;
  localparam int T_AAP_NS  = 40;
  localparam int T_WLC_NS  = 30;
  localparam int T_ZZL_US  = 1;
  localparam int T_ZZEX_US = 500;
  localparam int T_PU_MS   = 1;

  // ---------------------------------------------------------------
  // Derived cycle counts
  // ---------------------------------------------------------------
  localparam int WP_CYC       = ns_to_cyc(T_WP_NS);
  localparam int WZ_CYC       = ns_to_cyc(T_WZ_NS);
  localparam int DS_CYC       = ns_to_cyc(T_DS_NS);
  localparam int CW_CYC       = ns_to_cyc(T_CW_NS);
  localparam int CA_CYC       = ns_to_cyc(T_CA_NS);
  localparam int PWC_CYC      = ns_to_cyc(T_PWC_NS);
  localparam int BDS_CYC      = ns_to_cyc(T_BDS_NS);
  localparam int BDH_CYC      = ns_to_cyc(T_BDH_NS);
  localparam int PC_CYC       = ns_to_cyc(T_PC_NS);
  localparam int AA_CYC       = ns_to_cyc(T_AA_NS);
  localparam int AAP_CYC      = ns_to_cyc(T_AAP_NS);
  localparam int WLC_CYC      = ns_to_cyc(T_WLC_NS);
  localparam int ZZL_CYC      = ns_to_cyc(T_ZZL_US * 1000);
  localparam int ZZEX_CYC     = ns_to_cyc(T_ZZEX_US * 1000);
  localparam int PU_CYC       = ns_to_cyc(T_PU_MS * 1000000);
  localparam int PIN_LAT      = 1;
  localparam int SYNC_LAT     = 4;
  localparam int PAGE_OVH_CYC = 3;
  localparam int WE_LOW_CYC   = max_int(max_int(WP_CYC, WZ_CYC + DS_CYC),
                                        PWC_CYC - PAGE_OVH_CYC);

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int          ADDR_W    = 16;
  localparam int          DATA_W    = 16;
  localparam int          CNT_W     = 17;
  localparam int          AGE_W     = 8;
  localparam logic [1:0]  LANES_OFF = 2'h3;
  localparam logic [15:0] ADDR_RST  = 16'h0000;
  localparam logic [15:0] DATA_RST  = 16'h0000;

  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    ST_PWRUP  = 9'h001,
    ST_IDLE   = 9'h002,
    ST_READ   = 9'h004,
    ST_WSETUP = 9'h008,
    ST_WLOW   = 9'h010,
    ST_WHOLD  = 9'h020,
    ST_PAGE   = 9'h040,
    ST_PRECH  = 9'h080,
    ST_SLEEP  = 9'h100
  } nvrhc_state_t;

endpackage
`default_nettype wire

// *** tb/nvrhc_ram_model.sv ***
`default_nettype none
module nvrhc_ram_model
  import nvrhc_pkg::*;
#(
  parameter int ACC_NS  = 105,
  parameter int PAGE_NS = 40,
  parameter int WX_NS   = 10
)(
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_cs_n,
  input  wire logic              mem_we_n,
  input  wire logic              mem_oe_n,
  input  wire logic              upper_byte_lane_n,
  input  wire logic              lower_byte_lane_n,
  input  wire logic              sleep_request_n,
  input  wire logic [DATA_W-1:0] mem_dq_out,
  input  wire logic              mem_dq_oe_n,
  output logic [DATA_W-1:0]      dq_level,
  output wire logic              dev_drv
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Storage and access timing
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem [0:65535];
  logic [DATA_W-1:0] last_r  = 16'h0000;
  logic [ADDR_W-1:0] wr_addr = 16'h0000;
  logic              wr_open = 1'b0;
  wire logic [13:0]  up_d;
  wire logic [1:0]   lo_d;
  wire logic         cs_d;
  wire logic         we_d;
  wire logic         ok;

  // Delayed copies tell when a new row or column has settled.
  assign #(ACC_NS) up_d = mem_addr[15:2];
  assign #(PAGE_NS) lo_d = mem_addr[1:0];
  assign #(ACC_NS) cs_d = mem_cs_n;
  assign #(WX_NS) we_d = mem_we_n;
  assign ok = (up_d === mem_addr[15:2]) && (lo_d === mem_addr[1:0]) && (cs_d === 1'b0);

  // The device drives only when selected, awake, gated and out of a write.
  assign dev_drv = (sleep_request_n === 1'b1) && (mem_cs_n === 1'b0) &&
                   (mem_oe_n === 1'b0) && (mem_we_n === 1'b1) && (we_d === 1'b1);

  // Wire level: an undriven bus shows the inverse of its last value.
  always @(mem_dq_out or mem_dq_oe_n or dev_drv or ok or mem_addr)
  begin
    if (mem_dq_oe_n === 1'b0 || (dev_drv && ok))
    begin
      last_r = (mem_dq_oe_n === 1'b0) ? mem_dq_out : mem[mem_addr];
      dq_level = last_r;
    end
    else
      dq_level = ~last_r;
  end

  // A write opens on a strobe or select fall and latches the address.
  always @(negedge mem_we_n or negedge mem_cs_n)
    if (sleep_request_n === 1'b1 && mem_we_n === 1'b0 && mem_cs_n === 1'b0)
    begin
      wr_open = 1'b1;
      wr_addr = mem_addr;
    end

  // The first rising edge of strobe or select commits the enabled lanes.
  always @(posedge mem_we_n or posedge mem_cs_n or negedge sleep_request_n)
    if (wr_open)
    begin
      wr_open = 1'b0;
      if (sleep_request_n === 1'b1 && lower_byte_lane_n === 1'b0)
        mem[wr_addr][7:0] = dq_level[7:0];
      if (sleep_request_n === 1'b1 && upper_byte_lane_n === 1'b0)
        mem[wr_addr][15:8] = dq_level[15:8];
    end
endmodule
`default_nettype wire

// *** tb/nvrhc_host_test.sv ***
`default_nettype none
module nvrhc_host_test
  import nvrhc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PU_T   = 40;
  localparam int ZZEX_T = 20;
  localparam int LIMIT  = 8000;

  logic              clk        = 1'b0;
  logic              rst_n;
  logic              ce;
  logic              page_en;
  logic              sleep_req;
  logic              req_valid;
  logic              req_write;
  logic [15:0]       req_addr;
  logic [15:0]       req_wdata;
  logic [1:0]        req_lane_n;
  wire logic         req_ready;
  wire logic         rsp_valid;
  wire logic [15:0]  rsp_rdata;
  wire logic         link_ready;
  wire logic         sleep_active;
  wire logic [15:0]  mem_addr;
  wire logic         mem_cs_n;
  wire logic         mem_we_n;
  wire logic         mem_oe_n;
  wire logic         ub_n;
  wire logic         lb_n;
  wire logic         sleep_request_n;
  wire logic [15:0]  mem_dq_in;
  wire logic [15:0]  mem_dq_out;
  wire logic         mem_dq_oe_n;
  wire logic         dev_drv;
  int                mismatches  = 0;
  int                check_count = 0;
  int                cyc         = 0;

  always #4 clk = ~clk;

  nvrhc_host #(.PU_CYCLES(17'h00028), .ZZEX_CYCLES(17'h00014)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .page_en(page_en), .sleep_req(sleep_req),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_lane_n(req_lane_n),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .link_ready(link_ready),
    .sleep_active(sleep_active), .mem_addr(mem_addr), .mem_cs_n(mem_cs_n),
    .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .upper_byte_lane_n(ub_n),
    .lower_byte_lane_n(lb_n), .sleep_request_n(sleep_request_n),
    .mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n));

  nvrhc_ram_model ram (
    .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n),
    .upper_byte_lane_n(ub_n), .lower_byte_lane_n(lb_n), .sleep_request_n(sleep_request_n),
    .mem_dq_out(mem_dq_out), .mem_dq_oe_n(mem_dq_oe_n), .dq_level(mem_dq_in),
    .dev_drv(dev_drv));

  // ---------------------------------------------------------------
  // Reporting
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      mismatches++;
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Pin timing monitor, counted in sampled cycles of 8 ns
  // ---------------------------------------------------------------
  int          we_lo = 0;
  int          cs_lo = 0;
  int          cs_hi = 100;
  int          since_fall = 100;
  logic        we_p  = 1'b1;
  logic        cs_p  = 1'b1;
  logic        wrote = 1'b0;
  logic [17:0] pins_p = 18'h00000;

  // Checks each strobe edge, each select fall and each select rise after a write against its least spacing.
  always @(posedge clk)
  begin
    if (rst_n === 1'b1)
    begin
      check("dq_contention", 16'(dev_drv && mem_dq_oe_n === 1'b0), 16'h0000);
      if (we_p === 1'b0 || mem_we_n === 1'b0)
        check("lane_addr_hold", 16'({ub_n, lb_n, mem_addr} == pins_p), 16'h0001);
      if (we_p === 1'b0 && mem_we_n === 1'b1)
      begin
        check("we_low_width", 16'(we_lo >= 3), 16'h0001);
        check("cs_to_we_rise", 16'(cs_lo >= 9), 16'h0001);
      end
      if (we_p === 1'b1 && mem_we_n === 1'b0)
        check("we_spacing", 16'(since_fall >= 5), 16'h0001);
      if (cs_p === 1'b0 && mem_cs_n === 1'b1 && wrote)
        check("cs_active_write", 16'(cs_lo >= 9 && since_fall >= 4), 16'h0001);
      if (cs_p === 1'b1 && mem_cs_n === 1'b0)
        check("precharge", 16'(cs_hi >= 5), 16'h0001);
    end
    if (we_p === 1'b1 && mem_we_n === 1'b0)
      wrote = 1'b1;
    else if (mem_cs_n === 1'b1)
      wrote = 1'b0;
    since_fall = (we_p === 1'b1 && mem_we_n === 1'b0) ? 1 :
                 (mem_cs_n === 1'b1) ? 100 : since_fall + 1;
    we_lo = (mem_we_n === 1'b0) ? we_lo + 1 : 0;
    cs_lo = (mem_cs_n === 1'b0) ? cs_lo + 1 : 0;
    cs_hi = (mem_cs_n === 1'b1) ? cs_hi + 1 : 0;
    we_p = mem_we_n;
    cs_p = mem_cs_n;
    pins_p = {ub_n, lb_n, mem_addr};
  end

  // ---------------------------------------------------------------
  // Request tasks
  // ---------------------------------------------------------------
  task automatic req(input logic w, input logic [15:0] a, input logic [15:0] d,
                     input logic [1:0] ln);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    req_lane_n <= ln;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 500)
    begin
      @(negedge clk);
      n++;
    end
    check("req_taken", 16'(n < 500), 16'h0001);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    int n;
    n = 0;
    req(1'b0, a, 16'h0000, 2'h0);
    while (rsp_valid !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    d = (n < 100) ? rsp_rdata : 16'hxxxx;
  endtask

  task automatic wait_link(output int n);
    n = 0;
    @(negedge clk);
    while (link_ready !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    int n;
    repeat (2) @(posedge clk);
    check("reset_pins", 16'({mem_cs_n, mem_we_n, sleep_request_n, mem_dq_oe_n}), 16'h000f);
    rst_n <= 1'b1;
    wait_link(n);
    check("powerup_wait", 16'(n >= PU_T), 16'h0001);
    $display("test reset done");
  endtask

  task automatic t_page();
    logic [1:0]  wo [4];
    logic [15:0] d;
    wo = '{2'h2, 2'h0, 2'h3, 2'h1};
    @(posedge clk) page_en <= 1'b1;
    foreach (wo[i])
      req(1'b1, {14'h0010, wo[i]}, {14'h1690, wo[i]}, 2'h0);
    foreach (wo[i])
    begin
      rd({14'h0010, wo[3-i]}, d);
      check("page_word", d, {14'h1690, wo[3-i]});
    end
    $display("test page done");
  endtask

  task automatic t_lanes();
    logic [1:0]  ln [4];
    logic [15:0] wd [4];
    logic [15:0] ex [4];
    logic [15:0] d;
    ln = '{2'h0, 2'h2, 2'h1, 2'h3};
    wd = '{16'h1234, 16'habcd, 16'h5678, 16'h9999};
    ex = '{16'h1234, 16'h12cd, 16'h56cd, 16'h56cd};
    @(posedge clk) page_en <= 1'b0;
    foreach (ln[i])
    begin
      req(1'b1, 16'h2000, wd[i], ln[i]);
      rd(16'h2000, d);
      check("lane_word", d, ex[i]);
    end
    @(posedge clk) page_en <= 1'b1;
    rd(16'h0041, d);
    check("open_page", d, 16'h5a41);
    rd(16'h2000, d);
    check("page_miss", d, 16'h56cd);
    $display("test lanes done");
  endtask

  task automatic t_sleep();
    int          n;
    logic [15:0] d;
    n = 0;
    req(1'b1, 16'h7ffe, 16'hbeef, 2'h0);
    sleep_req <= 1'b1;
    @(negedge clk);
    while (sleep_active !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check("asleep_pins", 16'({sleep_request_n, mem_cs_n, mem_we_n}), 16'h0003);
    @(posedge clk);
    sleep_req <= 1'b0;
    while (sleep_active !== 1'b0)
      @(negedge clk);
    wait_link(n);
    check("wake_wait", 16'(n >= ZZEX_T - 1), 16'h0001);
    rd(16'h7ffe, d);
    check("kept_word", d, 16'hbeef);
    $display("test sleep done");
  endtask

  // Main sequence.
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    page_en = 1'b0;
    sleep_req = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 16'h0000;
    req_lane_n = 2'h3;
    t_reset();
    t_page();
    t_lanes();
    t_sleep();
    close_out();
  end
endmodule
`default_nettype wire
